// ---- erxos_pkg.sv ----
// What this block does
// [R1] First received alignment-word bit lands in bit 7 of the alignment register.
// [R2] Alignment-word bits two to eight land in bits 6..0; good pattern is 0011011.
// [R3] Half-second status bit toggles every 0.5 s, in phase with the one-second bit.
// [R4] One-second status bit toggles each second, giving a two-second period.
// [R5] Non-normal frames for 100 ms set the first timer bit; second bit clears it.
// [R6] Terminal sync held 10 ms sets the second timer bit; non-normal frames clear it.
// [R7] Long CRC-4 multiframe timer (400 ms) toggles its status bit on each expiry.
// [R8] Short CRC-4 multiframe timer (8 ms) toggles its own status bit on each expiry.
// [R9] CRC alignment bit toggles each ms; once aligned, on the CRC-4 sync signal.
// [R10] Keep-alive rises after AIS held 100 ms; falls as soon as AIS drops.
// [R11] First non-alignment-word bit lands in bit 7 of the non-alignment register.
// [R12] Second non-alignment-word bit lands in bit 6; it should read one.
// [R13] Third non-alignment-word bit, the remote alarm, lands in bit 5.
// [R14] Non-alignment-word bits four to eight land in bits 4..0.
// [R15] Time slot 16 frame-zero bits one to four land in bits 7..4; good is 0000.
// [R16] Time slot 16 frame-zero bits five to eight land in bits 3..0.
// [R17] Slip indicator inverts on every controlled frame slip.
// [R18] Slip direction: one for a repeated frame, zero for a lost frame.
// [R19] Alternating 1010 stream for 512 bits, tolerating errors, sets the pattern bit.
// [R20] Double-errored bit is set when the last two alignment words were both errored.
// [R21] Bits 3..0 show the upper four bits of the 12-bit eighth-bit phase count.
// [R22] A companion register shows the lower eight bits of the phase count.
// [R23] Status registers are read-only; writes change nothing.
// [R24] Each captured field updates once per received frame or multiframe.
package erxos_pkg;
	// ============================================================
	// Clock and time
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
	localparam int unsigned HALF_SEC_MS   = 500;
	localparam int unsigned NONNORMAL_MS  = 100;
	localparam int unsigned TSYNC_MS      = 10;
	localparam int unsigned CRC_LONG_MS   = 400;
	localparam int unsigned CRC_SHORT_MS  = 8;
	localparam int unsigned KEEPALIVE_MS  = 100;
	// Eighth-bit rate as a fraction of the clock, both in kHz
	localparam int unsigned LINE_KBPS     = 2048;
	localparam int unsigned SUBBITS       = 8;
	localparam int unsigned EIGHTH_INC    = LINE_KBPS * SUBBITS;
	localparam int unsigned EIGHTH_MOD    = CLK_HZ / MS_PER_S;
	// ============================================================
	// Line patterns
	localparam logic [6:0] FAS_PATTERN   = 7'h1B;
	localparam int unsigned AUX_RUN_BITS = 512;
	localparam int unsigned AUX_MAX_ERR  = 4;
	// ============================================================
	// Register indices (byte address is four times the index)
	localparam int unsigned APB_AW        = 8;
	localparam logic [4:0] IDX_ALIGN     = 5'h11;
	localparam logic [4:0] IDX_TIMER     = 5'h12;
	localparam logic [4:0] IDX_NONALIGN  = 5'h13;
	localparam logic [4:0] IDX_MFRAME    = 5'h14;
	localparam logic [4:0] IDX_PHASE_HI  = 5'h15;
	localparam logic [4:0] IDX_PHASE_LO  = 5'h16;
	localparam logic [4:0] IDX_CTRL      = 5'h1B;
	localparam logic [7:0] CTRL_RESET    = 8'h01;
	localparam int unsigned CTRL_AUX_EN  = 0;
endpackage

// ---- erxos_top.sv ----
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module erxos_top #(
	parameter int unsigned P_CYCLES_PER_MS = erxos_pkg::CYCLES_PER_MS,
	parameter int unsigned P_AUX_MAX_ERR   = erxos_pkg::AUX_MAX_ERR
) (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [erxos_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Overhead word strobes from the receive framer
	input  wire logic                        fas_valid,
	input  wire logic [7:0]                  fas_byte,
	input  wire logic                        nfas_valid,
	input  wire logic [7:0]                  nfas_byte,
	input  wire logic                        mfas_valid,
	input  wire logic [7:0]                  ts16_byte,
	// Received bit stream
	input  wire logic                        rx_bit_valid,
	input  wire logic                        rx_bit,
	// Framer status levels and events
	input  wire logic                        nonnormal_frames,
	input  wire logic                        terminal_sync,
	input  wire logic                        ais_status,
	input  wire logic                        crc_mf_search,
	input  wire logic                        crc_aligned,
	input  wire logic                        crc_sync_pulse,
	// Elastic buffer slips
	input  wire logic                        slip_event,
	input  wire logic                        slip_repeat,
	// Frame pulses for the phase count
	input  wire logic                        backplane_frame_pulse,
	input  wire logic                        rx_frame_pulse
);
	initial begin
		if (P_CYCLES_PER_MS < 2 || P_CYCLES_PER_MS > 131072) begin
			$error("P_CYCLES_PER_MS out of range");
		end
		if (P_AUX_MAX_ERR > 255) begin
			$error("P_AUX_MAX_ERR out of range");
		end
	end

	// ============================================================
	// Millisecond enable
	logic [16:0] ms_div;
	logic        ms_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_div  <= 17'h00000;
			ms_tick <= 1'b0;
		end else if (ms_div == 17'(P_CYCLES_PER_MS - 1)) begin
			ms_div  <= 17'h00000;
			ms_tick <= 1'b1;
		end else begin
			ms_div  <= ms_div + 17'h00001;
			ms_tick <= 1'b0;
		end
	end

	// ============================================================
	// Free-running half and one second toggles
	logic [8:0] half_cnt;
	logic       half_second_toggle;
	logic       one_second_toggle;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt           <= 9'h000;
			half_second_toggle <= 1'b0;
			one_second_toggle  <= 1'b0;
		end else if (ms_tick) begin
			if (half_cnt == 9'(erxos_pkg::HALF_SEC_MS - 1)) begin
				half_cnt           <= 9'h000;
				half_second_toggle <= ~half_second_toggle; // [R3]
				// Slower bit flips only on the falling half toggle, so both stay in phase
				if (half_second_toggle) begin
					one_second_toggle <= ~one_second_toggle; // [R4]
				end
			end else begin
				half_cnt <= half_cnt + 9'h001;
			end
		end
	end

	// ============================================================
	// Non-normal frame and terminal sync timers
	logic [6:0] nn_cnt;
	logic [3:0] ts_cnt;
	logic       nonnormal_frame_timer;
	logic       terminal_sync_timer;
	logic       t2_set;

	// Persistence is measured in whole ms ticks, so it may come up to 1 ms early
	assign t2_set = ms_tick && terminal_sync && !nonnormal_frames
		&& ts_cnt == 4'(erxos_pkg::TSYNC_MS - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nn_cnt                <= 7'h00;
			nonnormal_frame_timer <= 1'b0;
		end else if (!nonnormal_frames) begin
			nn_cnt <= 7'h00;
			if (t2_set) begin
				nonnormal_frame_timer <= 1'b0; // [R5]
			end
		end else if (ms_tick) begin
			if (nn_cnt == 7'(erxos_pkg::NONNORMAL_MS - 1)) begin
				nonnormal_frame_timer <= 1'b1; // [R5]
			end else begin
				nn_cnt <= nn_cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_cnt              <= 4'h0;
			terminal_sync_timer <= 1'b0;
		end else if (nonnormal_frames) begin
			ts_cnt              <= 4'h0;
			terminal_sync_timer <= 1'b0; // [R6]
		end else if (!terminal_sync) begin
			ts_cnt <= 4'h0;
		end else if (t2_set) begin
			terminal_sync_timer <= 1'b1; // [R6]
		end else if (ms_tick) begin
			ts_cnt <= ts_cnt + 4'h1;
		end
	end

	// ============================================================
	// CRC-4 multiframe alignment timers, running while searching
	logic [8:0] crc_long_cnt;
	logic [3:0] crc_short_cnt;
	logic       crc_mf_long_timer_toggle;
	logic       crc_mf_short_timer_toggle;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_long_cnt             <= 9'h000;
			crc_mf_long_timer_toggle <= 1'b0;
		end else if (!crc_mf_search) begin
			crc_long_cnt <= 9'h000;
		end else if (ms_tick) begin
			if (crc_long_cnt == 9'(erxos_pkg::CRC_LONG_MS - 1)) begin
				crc_long_cnt             <= 9'h000;
				crc_mf_long_timer_toggle <= ~crc_mf_long_timer_toggle; // [R7]
			end else begin
				crc_long_cnt <= crc_long_cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_short_cnt             <= 4'h0;
			crc_mf_short_timer_toggle <= 1'b0;
		end else if (!crc_mf_search) begin
			crc_short_cnt <= 4'h0;
		end else if (ms_tick) begin
			if (crc_short_cnt == 4'(erxos_pkg::CRC_SHORT_MS - 1)) begin
				crc_short_cnt             <= 4'h0;
				crc_mf_short_timer_toggle <= ~crc_mf_short_timer_toggle; // [R8]
			end else begin
				crc_short_cnt <= crc_short_cnt + 4'h1;
			end
		end
	end

	// ============================================================
	// CRC alignment toggle and keep-alive
	logic       crc_align_ms_toggle;
	logic [6:0] ka_cnt;
	logic       keep_alive;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_align_ms_toggle <= 1'b0;
		end else if (crc_aligned ? crc_sync_pulse : ms_tick) begin
			crc_align_ms_toggle <= ~crc_align_ms_toggle; // [R9]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ka_cnt     <= 7'h00;
			keep_alive <= 1'b0;
		end else if (!ais_status) begin
			ka_cnt     <= 7'h00;
			keep_alive <= 1'b0; // [R10]
		end else if (ms_tick) begin
			if (ka_cnt == 7'(erxos_pkg::KEEPALIVE_MS - 1)) begin
				keep_alive <= 1'b1; // [R10]
			end else begin
				ka_cnt <= ka_cnt + 7'h01;
			end
		end
	end

	// ============================================================
	// Overhead word captures
	logic [7:0] rx_alignment_word;
	logic [7:0] rx_non_alignment_word;
	logic [7:0] rx_multiframe_alignment_word;
	logic       fas_err_prev;
	logic       double_errored_align;
	logic       fas_err;

	assign fas_err = fas_byte[6:0] != erxos_pkg::FAS_PATTERN;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_alignment_word    <= 8'h00;
			fas_err_prev         <= 1'b0;
			double_errored_align <= 1'b0;
		end else if (fas_valid) begin
			rx_alignment_word    <= fas_byte; // [R1] [R2] [R24]
			fas_err_prev         <= fas_err;
			double_errored_align <= fas_err && fas_err_prev; // [R20]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_non_alignment_word <= 8'h00;
		end else if (nfas_valid) begin
			rx_non_alignment_word <= nfas_byte; // [R11] [R12] [R13] [R14] [R24]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_multiframe_alignment_word <= 8'h00;
		end else if (mfas_valid) begin
			rx_multiframe_alignment_word <= ts16_byte; // [R15] [R16] [R24]
		end
	end

	// ============================================================
	// Slips
	logic rx_slip_toggle;
	logic rx_slip_direction;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_slip_toggle    <= 1'b0;
			rx_slip_direction <= 1'b0;
		end else if (slip_event) begin
			rx_slip_toggle    <= ~rx_slip_toggle; // [R17]
			rx_slip_direction <= slip_repeat; // [R18]
		end
	end

	// ============================================================
	// Alternating pattern detector, judged over 512-bit windows
	logic [7:0] ctrl;
	logic [8:0] aux_bits;
	logic [7:0] aux_errs;
	logic       aux_prev;
	logic       alternating_pattern_detect;
	logic       aux_bad;

	assign aux_bad = rx_bit == aux_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_bits                   <= 9'h000;
			aux_errs                   <= 8'h00;
			aux_prev                   <= 1'b0;
			alternating_pattern_detect <= 1'b0;
		end else if (!ctrl[erxos_pkg::CTRL_AUX_EN]) begin
			aux_bits                   <= 9'h000;
			aux_errs                   <= 8'h00;
			alternating_pattern_detect <= 1'b0;
		end else if (rx_bit_valid) begin
			aux_prev <= rx_bit;
			if (aux_bits == 9'(erxos_pkg::AUX_RUN_BITS - 1)) begin
				aux_bits <= 9'h000;
				aux_errs <= 8'h00;
				// A single line error breaks alternation twice, hence the error budget
				// Nine bits, so a saturated error count cannot wrap round to a pass
				alternating_pattern_detect <= ({1'b0, aux_errs} + {8'h00, aux_bad})
					<= {1'b0, 8'(P_AUX_MAX_ERR)}; // [R19]
			end else begin
				aux_bits <= aux_bits + 9'h001;
				if (aux_bad && aux_errs != 8'hFF) begin
					aux_errs <= aux_errs + 8'h01;
				end
			end
		end
	end

	// ============================================================
	// Eighth-bit phase between backplane and receive frame pulses
	logic [17:0] eb_acc;
	logic        eb_tick;
	logic [11:0] eb_cnt;
	logic [11:0] rx_eighth_bit_phase_count;
	logic [17:0] eb_sum;

	// One bit of headroom: the modulus plus the increment exceeds 17 bits
	assign eb_sum = eb_acc + 18'(erxos_pkg::EIGHTH_INC);

	// Fractional divider: ticks at 16.384 MHz on average, jitter of one pclk period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eb_acc  <= 18'h00000;
			eb_tick <= 1'b0;
		end else if (eb_sum >= 18'(erxos_pkg::EIGHTH_MOD)) begin
			eb_acc  <= eb_sum - 18'(erxos_pkg::EIGHTH_MOD);
			eb_tick <= 1'b1;
		end else begin
			eb_acc  <= eb_sum;
			eb_tick <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eb_cnt <= 12'h000;
		end else if (backplane_frame_pulse) begin
			eb_cnt <= 12'h000;
		end else if (eb_tick && eb_cnt != 12'hFFF) begin
			eb_cnt <= eb_cnt + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_eighth_bit_phase_count <= 12'h000;
		end else if (rx_frame_pulse) begin
			rx_eighth_bit_phase_count <= eb_cnt; // [R21] [R22]
		end
	end

	// ============================================================
	// APB slave: one wait-free access phase, answer prepared in setup
	logic [4:0] idx;
	logic       addr_ok;
	logic       mapped;
	logic [7:0] rd_mux;
	logic [7:0] timer_status_word;
	logic [7:0] phase_status_high;

	assign idx     = paddr[6:2];
	assign addr_ok = paddr[1:0] == 2'h0 && paddr[erxos_pkg::APB_AW-1] == 1'b0;
	assign timer_status_word = {half_second_toggle, one_second_toggle,
		nonnormal_frame_timer, terminal_sync_timer, crc_mf_long_timer_toggle,
		crc_mf_short_timer_toggle, crc_align_ms_toggle, keep_alive};
	assign phase_status_high = {rx_slip_toggle, rx_slip_direction,
		alternating_pattern_detect, double_errored_align,
		rx_eighth_bit_phase_count[11:8]}; // [R21]

	always_comb begin
		mapped = addr_ok;
		rd_mux = 8'h00;
		unique case (idx)
			erxos_pkg::IDX_ALIGN:    rd_mux = rx_alignment_word;
			erxos_pkg::IDX_TIMER:    rd_mux = timer_status_word;
			erxos_pkg::IDX_NONALIGN: rd_mux = rx_non_alignment_word;
			erxos_pkg::IDX_MFRAME:   rd_mux = rx_multiframe_alignment_word;
			erxos_pkg::IDX_PHASE_HI: rd_mux = phase_status_high;
			erxos_pkg::IDX_PHASE_LO: rd_mux = rx_eighth_bit_phase_count[7:0]; // [R22]
			erxos_pkg::IDX_CTRL:     rd_mux = ctrl;
			default:                 mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !mapped;
				prdata  <= (mapped && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
			end
		end
	end

	// Only the control register accepts writes; status words ignore them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= erxos_pkg::CTRL_RESET;
		end else if (psel && penable && pready && pwrite && addr_ok
			&& idx == erxos_pkg::IDX_CTRL) begin
			ctrl <= {7'h00, pwdata[erxos_pkg::CTRL_AUX_EN]}; // [R23]
		end
	end

	// ============================================================
	// Assertions
	a_fas_capture: assert property (@(posedge pclk) disable iff (!presetn) // [R1] [R2]
		fas_valid |=> rx_alignment_word == $past(fas_byte))
		else $error("alignment word not captured");
	a_nfas_capture: assert property (@(posedge pclk) disable iff (!presetn) // [R11] [R13]
		nfas_valid |=> rx_non_alignment_word == $past(nfas_byte))
		else $error("non-alignment word not captured");
	a_ts16_capture: assert property (@(posedge pclk) disable iff (!presetn) // [R15] [R16]
		!mfas_valid |=> $stable(rx_multiframe_alignment_word))
		else $error("multiframe word changed without a strobe");
	a_slip_report: assert property (@(posedge pclk) disable iff (!presetn) // [R17] [R18]
		slip_event |=> $changed(rx_slip_toggle) && rx_slip_direction == $past(slip_repeat))
		else $error("slip not reported");
	a_double_err: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		fas_valid |=> double_errored_align == ($past(fas_err) && $past(fas_err_prev)))
		else $error("double errored alignment wrong");
	a_timer_phase: assert property (@(posedge pclk) disable iff (!presetn) // [R3] [R4]
		$changed(one_second_toggle) |-> $changed(half_second_toggle) && !half_second_toggle)
		else $error("second toggles out of phase");
	a_isdn_excl: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
		!(nonnormal_frame_timer && terminal_sync_timer))
		else $error("both isdn timers high");
	a_keep_drop: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		!ais_status |=> !keep_alive)
		else $error("keep alive not cleared");
	a_crc_expire: assert property (@(posedge pclk) disable iff (!presetn) // [R7] [R8]
		$changed(crc_mf_long_timer_toggle) |-> $changed(crc_mf_short_timer_toggle)
		&& $past(crc_mf_search) && $past(ms_tick))
		else $error("crc timers out of step");
	a_crc_align_ms_toggle_sync: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		crc_aligned && crc_sync_pulse |=> $changed(crc_align_ms_toggle))
		else $error("crc alignment toggle missed sync");
	a_phase_latch: assert property (@(posedge pclk) disable iff (!presetn) // [R21] [R22]
		rx_frame_pulse |=> rx_eighth_bit_phase_count == $past(eb_cnt))
		else $error("phase count not latched");
	a_ro_write: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
		psel && penable && pwrite && !fas_valid |=> $stable(rx_alignment_word))
		else $error("write changed a status word");
	a_aux_off: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		!ctrl[erxos_pkg::CTRL_AUX_EN] |=> !alternating_pattern_detect)
		else $error("pattern detect while disabled");
endmodule
`default_nettype wire

// ---- erxos_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Far-end line terminal as seen through the receive framer
module erxos_line_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench control
	input  wire logic        run,
	input  wire logic        alt_mode,
	input  wire logic [7:0]  fas_word,
	input  wire logic [7:0]  nfas_word,
	input  wire logic [7:0]  ts16_word,
	// Framer strobes
	output logic             fas_valid,
	output logic [7:0]       fas_byte,
	output logic             nfas_valid,
	output logic [7:0]       nfas_byte,
	output logic             mfas_valid,
	output logic [7:0]       ts16_byte,
	output logic             rx_bit_valid,
	output logic             rx_bit,
	output logic             bp_pulse,
	output logic             rxf_pulse
);
	logic [11:0] cnt;
	logic        fr;
	assign fr = run && cnt[3:0] == 4'h0;
	// Idle data lines keep changing so a stale value is never mistaken for a capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 12'h000;
			{fas_valid, nfas_valid, mfas_valid, rx_bit_valid, rx_bit} <= 5'h00;
			{fas_byte, nfas_byte, ts16_byte} <= 24'h000000;
			{bp_pulse, rxf_pulse} <= 2'h0;
		end else begin
			cnt <= run ? cnt + 12'h001 : 12'h000;
			fas_valid <= fr && !cnt[4];
			nfas_valid <= fr && cnt[4];
			mfas_valid <= run && cnt[5:0] == 6'h08;
			fas_byte <= (fr && !cnt[4]) ? fas_word : ~fas_byte;
			nfas_byte <= (fr && cnt[4]) ? nfas_word : ~nfas_byte;
			ts16_byte <= (run && cnt[5:0] == 6'h08) ? ts16_word : ~ts16_byte;
			rx_bit_valid <= run;
			rx_bit <= (alt_mode || !run) ? ~rx_bit : 1'($urandom());
			bp_pulse <= run && cnt == 12'h000;
			rxf_pulse <= run && cnt == 12'hFA0;
		end
	end
endmodule
`default_nettype wire

// ---- e1_rx_overhead_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module e1_rx_overhead_status_tb;
	// ============================================================
	// Signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, fas_byte, nfas_byte, ts16_byte, fas_word, nfas_word, ts16_word, d, s, wd;
	logic [31:0] pwdata, prdata;
	logic        fas_valid, nfas_valid, mfas_valid, rx_bit_valid, rx_bit, bp_pulse, rxf_pulse;
	logic        nonnormal_frames, terminal_sync, ais_status, crc_mf_search, crc_aligned;
	logic        crc_sync_pulse, slip_event, slip_repeat, run, alt_mode, e, st, r;
	logic [11:0] ph;
	int          fail_count, check_count, cyc, exp_ph;
	erxos_top #(.P_CYCLES_PER_MS(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fas_valid(fas_valid), .fas_byte(fas_byte),
		.nfas_valid(nfas_valid), .nfas_byte(nfas_byte), .mfas_valid(mfas_valid),
		.ts16_byte(ts16_byte), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
		.nonnormal_frames(nonnormal_frames), .terminal_sync(terminal_sync),
		.ais_status(ais_status), .crc_mf_search(crc_mf_search), .crc_aligned(crc_aligned),
		.crc_sync_pulse(crc_sync_pulse), .slip_event(slip_event), .slip_repeat(slip_repeat),
		.backplane_frame_pulse(bp_pulse), .rx_frame_pulse(rxf_pulse));
	erxos_line_model line_u (.pclk(pclk), .presetn(presetn), .run(run), .alt_mode(alt_mode),
		.fas_word(fas_word), .nfas_word(nfas_word), .ts16_word(ts16_word),
		.fas_valid(fas_valid), .fas_byte(fas_byte), .nfas_valid(nfas_valid),
		.nfas_byte(nfas_byte), .mfas_valid(mfas_valid), .ts16_byte(ts16_byte),
		.rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .bp_pulse(bp_pulse), .rxf_pulse(rxf_pulse));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;
	// ============================================================
	// Tasks
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; leaves one idle cycle behind it
	task automatic xfer(input logic [7:0] a, input logic w);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			end_of_test();
		end
		d = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0);
		chk(d, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ============================================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{fas_word, nfas_word, ts16_word} = 24'h000000;
		{nonnormal_frames, terminal_sync, ais_status, crc_mf_search, crc_aligned} = 5'h00;
		{crc_sync_pulse, slip_event, slip_repeat, run, alt_mode, st} = 6'h00;
		presetn = 1'b0;
		wd = 8'hFF;
		fail_count = 0;
		check_count = 0;
		void'($urandom(18188));
		wait_cyc(8);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(8'h44, 8'h00);
		rdc(8'h4C, 8'h00);
		rdc(8'h50, 8'h00);
		rdc(8'h6C, 8'h01);
		xfer(8'h70, 1'b0);
		chk({7'h00, e}, 8'h01);
		xfer(8'h45, 1'b0);
		chk({7'h00, e}, 8'h01);
		run <= 1'b1;
		// Captured overhead words, first one a clean alignment word
		for (int i = 0; i < 5; i++) begin
			fas_word <= (i == 0) ? {1'b1, erxos_pkg::FAS_PATTERN} : 8'($urandom());
			nfas_word <= 8'($urandom());
			ts16_word <= (i == 0) ? 8'h0F : 8'($urandom());
			wait_cyc(140);
			rdc(8'h44, fas_word);
			rdc(8'h4C, nfas_word);
			rdc(8'h50, ts16_word);
		end
		xfer(8'h44, 1'b1);
		chk({7'h00, e}, 8'h00);
		rdc(8'h44, fas_word);
		fas_word <= 8'h00;
		wait_cyc(70);
		xfer(8'h54, 1'b0);
		chk({7'h00, d[4]}, 8'h01);
		fas_word <= {1'b0, erxos_pkg::FAS_PATTERN};
		wait_cyc(40);
		xfer(8'h54, 1'b0);
		chk({7'h00, d[4]}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = (i < 2) ? i[0] : 1'($urandom());
			slip_repeat <= r;
			slip_event <= 1'b1;
			@(posedge pclk);
			slip_event <= 1'b0;
			st = ~st;
			@(posedge pclk);
			xfer(8'h54, 1'b0);
			chk({6'h00, d[7:6]}, {6'h00, st, r});
		end
		// Once aligned, only the sync pulse moves the CRC alignment bit
		crc_aligned <= 1'b1;
		@(posedge pclk);
		xfer(8'h48, 1'b0);
		s = d;
		wait_cyc(30);
		rdc(8'h48, s) ;
		chk({7'h00, d[1]}, {7'h00, s[1]});
		crc_sync_pulse <= 1'b1;
		@(posedge pclk);
		crc_sync_pulse <= 1'b0;
		@(posedge pclk);
		xfer(8'h48, 1'b0);
		chk({7'h00, d[1]}, {7'h00, ~s[1]});
		crc_aligned <= 1'b0;
		crc_mf_search <= 1'b1;
		wait_cyc(40);
		xfer(8'h48, 1'b0);
		s = d;
		wait_cyc(80);
		xfer(8'h48, 1'b0);
		chk({6'h00, d[3:2]}, {6'h00, s[3], ~s[2]});
		wait_cyc(3925);
		xfer(8'h48, 1'b0);
		chk({6'h00, d[3:2]}, {6'h00, ~s[3], s[2]});
		crc_mf_search <= 1'b0;
		ais_status <= 1'b1;
		wait_cyc(900);
		xfer(8'h48, 1'b0);
		chk({7'h00, d[0]}, 8'h00);
		wait_cyc(200);
		xfer(8'h48, 1'b0);
		chk({7'h00, d[0]}, 8'h01);
		ais_status <= 1'b0;
		wait_cyc(2);
		xfer(8'h48, 1'b0);
		chk({7'h00, d[0]}, 8'h00);
		nonnormal_frames <= 1'b1;
		wait_cyc(1100);
		xfer(8'h48, 1'b0);
		chk({6'h00, d[5:4]}, 8'h02);
		nonnormal_frames <= 1'b0;
		terminal_sync <= 1'b1;
		wait_cyc(120);
		xfer(8'h48, 1'b0);
		chk({6'h00, d[5:4]}, 8'h01);
		nonnormal_frames <= 1'b1;
		wait_cyc(2);
		xfer(8'h48, 1'b0);
		chk({6'h00, d[5:4]}, 8'h00);
		{nonnormal_frames, terminal_sync} <= 2'h0;
		alt_mode <= 1'b1;
		wait_cyc(1100);
		xfer(8'h54, 1'b0);
		chk({7'h00, d[5]}, 8'h01);
		// Disabling the detector drops the bit even while the pattern still runs
		wd = 8'h00;
		xfer(8'h6C, 1'b1);
		rdc(8'h6C, 8'h00);
		xfer(8'h54, 1'b0);
		chk({7'h00, d[5]}, 8'h00);
		wd = 8'hFF;
		xfer(8'h6C, 1'b1);
		alt_mode <= 1'b0;
		wait_cyc(1100);
		xfer(8'h54, 1'b0);
		chk({7'h00, d[5]}, 8'h00);
		// Phase count spans 4000 cycles between the two frame pulses
		exp_ph = 4000 * erxos_pkg::EIGHTH_INC / erxos_pkg::EIGHTH_MOD;
		xfer(8'h58, 1'b0);
		ph[7:0] = d;
		xfer(8'h54, 1'b0);
		ph[11:8] = d[3:0];
		chk(8'(int'(ph) > exp_ph + 2 || int'(ph) + 2 < exp_ph), 8'h00);
		for (int k = 0; k < 3; k++) begin
			while (cyc < 12500 + 5000 * k) @(posedge pclk);
			xfer(8'h48, 1'b0);
			chk({6'h00, d[7:6]}, {6'h00, 1'(k + 2), 1'((k + 2) >> 1)});
		end
		end_of_test();
	end
endmodule
`default_nettype wire
